/* File: verilog/ccs_clock_ctrl.sv */
// cpu clock source control with its axi4-lite register slave
// Behaviour
// R1: ring oscillator always starts after reset release
// R2: build option decides if ring is stoppable
// R3: prescaler follows the ring/main source, also when sub feeds cpu
// R4: reset clears select bit, ring feeds cpu
// R5: cpu clock withheld for 17 ring cycles
// R6: both oscillators held stopped during reset
// R7: software checks stability before selecting main
// R8: read-only status bit shows current cpu source; the code shows ring or main only, also when sub feeds cpu
// R9: ring stop only when allowed, off-ring
// R10: main stop register acts only on ring
// R11: subsystem mode: control register gates main
// R12: stop ignored in subsystem mode, halt allowed
// R13: stop release on main waits selected time
// R14: software checks stability after ring stop release
// R15: control bit 6 turns feedback resistor off
// R16: cpu runs on ring without stabilization wait
// R17: status reads 0 on ring, 1 main
// R18: select field codes 1..5, reset value 5
// R19: stability flags set shortest first, sticky
// R20: status changes once switch really completed
`timescale 1ns/1ps
`include "ccs_cfg.svh"
module ccs_clock_ctrl
    import ccs_pkg::*;
#(
    parameter bit RING_STOPPABLE = 1'b1,
    parameter int RING_DIV       = `CCS_RING_DIV
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        main_osc_clk,
    input  wire logic        sub_osc_clk,
    input  wire logic        stop_req,
    input  wire logic        halt_req,
    input  wire logic        wake_req,
    output logic             main_osc_en,
    output logic             internal_ring_oscillator_en,
    output logic             sub_fb_res_off,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             cpu_on_main
);
    if (RING_DIV < 2 || RING_DIV > 65535) begin : g_bad_div
        $error("ccs_clock_ctrl: RING_DIV out of range");
    end

    // register state
    logic       sel_reg;
    logic       stat_reg;
    logic       rstop_reg;
    logic       mstop_reg;
    logic       mcc_reg;
    logic       fb_off_reg;
    logic       css_reg;
    logic [2:0] stsel_reg;
    logic       limit_on_reg;
    logic [4:0] stab_status;
    logic       stab_reached;

    // oscillator and clock state
    ccs_state_e state_reg;
    ccs_state_e state_next;
    logic [15:0] ring_div_reg;
    logic        ring_tick_reg;
    logic [4:0]  start_cnt_reg;
    logic        main_en_reg;
    logic        ring_en_reg;
    logic        cpu_en_reg;
    logic        per_en_reg;
    logic [2:0]  sync_reg [2];
    logic [1:0]  lvl_reg;
    logic [1:0]  tick_reg;

    // pin synchronisers; a level counts once stages two and three agree
    wire [1:0] pin_in = {sub_osc_clk, main_osc_clk};
    for (genvar p = 0; p < 2; p++) begin : g_pin
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync_reg[p] <= 3'h0;
                lvl_reg[p]  <= 1'b0;
                tick_reg[p] <= 1'b0;
            end else begin
                sync_reg[p] <= {sync_reg[p][1:0], pin_in[p]};
                if (sync_reg[p][1] == sync_reg[p][2]) begin
                    lvl_reg[p] <= sync_reg[p][2];
                end
                tick_reg[p] <= (sync_reg[p][1] == sync_reg[p][2])
                               && sync_reg[p][2] && !lvl_reg[p];
            end
        end
    end
    wire main_tick = tick_reg[0] && main_en_reg;
    wire sub_tick  = tick_reg[1];

    // ring oscillator modelled as an enable divider off aclk
    always_ff @(posedge aclk) begin
        if (!aresetn || !ring_en_reg) begin
            ring_div_reg  <= 16'h0000;
            ring_tick_reg <= 1'b0;
        end else begin
            ring_tick_reg <= (ring_div_reg == 16'(RING_DIV - 1));
            ring_div_reg  <= (ring_div_reg == 16'(RING_DIV - 1)) ? 16'h0000
                             : ring_div_reg + 16'h0001;
        end
    end

    // oscillator enables
    wire stop_entry = (state_reg == CCS_ST_RUN) && stop_req && !halt_req && !css_reg;
    wire main_on    = (state_reg != CCS_ST_STOP) && !stop_entry &&
                      (css_reg ? !mcc_reg : (stat_reg || !mstop_reg)); // R10 R11
    wire ring_on    = !(RING_STOPPABLE && rstop_reg && (stat_reg || css_reg)); // R2 R9
    wire sw_stop    = !main_on && (state_reg != CCS_ST_STOP) && !stop_entry;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_en_reg <= 1'b0; // R6
            ring_en_reg <= 1'b0; // R6
        end else begin
            main_en_reg <= main_on;
            ring_en_reg <= 1'b1 & ring_on; // R1
        end
    end

    // source switch completes on the first tick of the new source
    wire new_src_tick = sel_reg ? main_tick : ring_tick_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= 1'b0; // R4
        end else if (sel_reg != stat_reg && new_src_tick) begin
            stat_reg <= sel_reg; // R17 R20
        end
    end

    // cpu standby sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CCS_ST_START: begin
                if (ring_tick_reg && start_cnt_reg == 5'(`CCS_START_CYCLES - 1)) begin
                    state_next = CCS_ST_RUN; // R5 R16
                end
            end
            CCS_ST_RUN: begin
                if (halt_req) begin
                    state_next = CCS_ST_HALT; // R12
                end else if (stop_entry) begin
                    state_next = CCS_ST_STOP; // R12
                end
            end
            CCS_ST_HALT: begin
                if (wake_req) begin
                    state_next = CCS_ST_RUN;
                end
            end
            CCS_ST_STOP: begin
                if (wake_req) begin
                    state_next = stat_reg ? CCS_ST_STABWAIT : CCS_ST_RUN; // R13
                end
            end
            CCS_ST_STABWAIT: begin
                if (stab_reached) begin
                    state_next = CCS_ST_RUN; // R13
                end
            end
            default: state_next = CCS_ST_START;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg     <= CCS_ST_START;
            start_cnt_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            if (state_reg == CCS_ST_START && ring_tick_reg) begin
                start_cnt_reg <= start_cnt_reg + 5'h01; // R5
            end
        end
    end

    // clock enables toward cpu and prescaler
    wire cpu_src_tick = css_reg ? sub_tick : (stat_reg ? main_tick : ring_tick_reg);
    wire per_src_tick = stat_reg ? main_tick : ring_tick_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_en_reg <= 1'b0;
            per_en_reg <= 1'b0;
        end else begin
            cpu_en_reg <= (state_reg == CCS_ST_RUN) && cpu_src_tick; // R5 R16
            per_en_reg <= (state_reg != CCS_ST_STOP) && per_src_tick; // R3
        end
    end

    // after a stop release the flags only run up to the selected time
    always_ff @(posedge aclk) begin
        if (!aresetn || sw_stop) begin
            limit_on_reg <= 1'b0;
        end else if (stop_entry) begin
            limit_on_reg <= 1'b1;
        end
    end

    ccs_stab_counter #(
        .CNT_W(17)
    ) u_stab (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clear     (!main_en_reg),
        .tick      (main_tick),
        .limit_sel (stsel_reg),
        .limit_on  (limit_on_reg),
        .status    (stab_status),
        .reached   (stab_reached)
    ); // R19

    // axi4-lite slave: address and data may arrive in either order
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  aw_addr_reg;
    logic [7:0]  w_byte_reg;
    logic        w_lane_reg;
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    wire wr_fire  = aw_got_reg && w_got_reg && !bvalid_reg;
    wire wr_lane  = wr_fire && w_lane_reg;
    wire wr_mode  = wr_lane && aw_addr_reg == `CCS_ADDR_MODE;
    wire wr_rcm   = wr_lane && aw_addr_reg == `CCS_ADDR_RING_MODE;
    wire wr_mosc  = wr_lane && aw_addr_reg == `CCS_ADDR_MOSC_STOP;
    wire wr_stsel = wr_lane && aw_addr_reg == `CCS_ADDR_STAB_SEL;
    wire wr_pcc   = wr_lane && aw_addr_reg == `CCS_ADDR_PCC;
    wire wr_map   = aw_addr_reg == `CCS_ADDR_MODE || aw_addr_reg == `CCS_ADDR_RING_MODE ||
                    aw_addr_reg == `CCS_ADDR_MOSC_STOP || aw_addr_reg == `CCS_ADDR_STAB_SEL ||
                    aw_addr_reg == `CCS_ADDR_PCC || aw_addr_reg == `CCS_ADDR_STAB_STAT;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_byte_reg  <= 8'h00;
            w_lane_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `CCS_RESP_OKAY;
        end else begin
            awready_reg <= awvalid && !awready_reg && !aw_got_reg && !bvalid_reg;
            wready_reg  <= wvalid && !wready_reg && !w_got_reg && !bvalid_reg;
            if (awvalid && awready_reg) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready_reg) begin
                w_got_reg  <= 1'b1;
                w_byte_reg <= wdata[7:0];
                w_lane_reg <= wstrb[0];
            end
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_map ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
            end else if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // software-written control bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg    <= 1'b0; // R4
            rstop_reg  <= 1'b0;
            mstop_reg  <= 1'b0;
            mcc_reg    <= 1'b0;
            fb_off_reg <= 1'b0;
            css_reg    <= 1'b0;
            stsel_reg  <= `CCS_STAB_SEL_RESET; // R18
        end else begin
            if (wr_mode) sel_reg <= w_byte_reg[`CCS_MODE_SEL_BIT];
            if (wr_rcm) rstop_reg <= w_byte_reg[`CCS_RING_STOP_BIT];
            if (wr_mosc) mstop_reg <= w_byte_reg[`CCS_MOSC_STOP_BIT];
            if (wr_stsel) stsel_reg <= w_byte_reg[2:0]; // R18
            if (wr_pcc) begin
                mcc_reg    <= w_byte_reg[`CCS_PCC_MAIN_STOP];
                fb_off_reg <= w_byte_reg[`CCS_PCC_FB_OFF]; // R15
                css_reg    <= w_byte_reg[`CCS_PCC_SUB_SEL];
            end
        end
    end

    // read side
    wire [7:0] rd_mode  = {6'h00, stat_reg, sel_reg}; // R8
    wire [7:0] rd_rcm   = {7'h00, rstop_reg};
    wire [7:0] rd_mosc  = {mstop_reg, 7'h00};
    wire [7:0] rd_stab  = {3'h0, stab_status};
    wire [7:0] rd_stsel = {5'h00, stsel_reg};
    wire [7:0] rd_pcc   = {mcc_reg, fb_off_reg, 1'b0, css_reg, 4'h0};
    wire       rd_hit   = araddr[7:2] <= 6'h05;
    wire [7:0] rd_byte  = araddr[7:2] == 6'h00 ? rd_mode  :
                          araddr[7:2] == 6'h01 ? rd_rcm   :
                          araddr[7:2] == 6'h02 ? rd_mosc  :
                          araddr[7:2] == 6'h03 ? rd_stab  :
                          araddr[7:2] == 6'h04 ? rd_stsel :
                          araddr[7:2] == 6'h05 ? rd_pcc   : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `CCS_RESP_OKAY;
        end else begin
            arready_reg <= arvalid && !arready_reg && !rvalid_reg;
            if (arvalid && arready_reg) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= {24'h000000, rd_byte};
                rresp_reg  <= rd_hit ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
            end else if (rvalid_reg && rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign awready        = awready_reg;
    assign wready         = wready_reg;
    assign bvalid         = bvalid_reg;
    assign bresp          = bresp_reg;
    assign arready        = arready_reg;
    assign rvalid         = rvalid_reg;
    assign rdata          = rdata_reg;
    assign rresp          = rresp_reg;
    assign main_osc_en    = main_en_reg;
    assign internal_ring_oscillator_en    = ring_en_reg;
    assign sub_fb_res_off = fb_off_reg; // R15
    assign cpu_clk_en     = cpu_en_reg;
    assign periph_clk_en  = per_en_reg;
    assign cpu_on_main    = stat_reg; // R8 R17

    // checks
    reset_stops_a: assert property (@(posedge aclk) // R6
        $past(!aresetn) |-> !main_osc_en && !internal_ring_oscillator_en)
        else $error("oscillator running out of reset");
    ring_starts_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        $rose(aresetn) |=> internal_ring_oscillator_en)
        else $error("ring oscillator not started after reset");
    start_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        state_reg == CCS_ST_START |-> !cpu_clk_en ##0 start_cnt_reg <= 5'd17)
        else $error("cpu clocked during start hold");
    start_end_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        state_reg == CCS_ST_START && ring_tick_reg && start_cnt_reg == 5'd16
        |=> state_reg == CCS_ST_RUN)
        else $error("start hold not ended after 17 ring cycles");
    status_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // R20
        $changed(cpu_on_main) |-> $past(new_src_tick) && cpu_on_main == $past(sel_reg))
        else $error("status changed without completed switch");
    ring_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        !cpu_on_main && !css_reg && $past(!cpu_on_main && !css_reg) && $past(aresetn)
        |-> internal_ring_oscillator_en)
        else $error("ring oscillator stopped while it clocks the cpu");
    main_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        $past(cpu_on_main && !css_reg && state_reg != CCS_ST_STOP && !stop_entry)
        && $past(aresetn) |-> main_osc_en)
        else $error("main oscillator stopped while it clocks the cpu");
    sub_nostop_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        css_reg && state_reg == CCS_ST_RUN && stop_req && !halt_req
        |=> state_reg != CCS_ST_STOP)
        else $error("stop entered in subsystem mode");
    stab_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        state_reg == CCS_ST_STABWAIT && !stab_reached |=> !cpu_clk_en)
        else $error("cpu clocked before stabilization time");
    flag_order_a: assert property (@(posedge aclk) disable iff (!aresetn) // R19
        (stab_status[3:0] & ~stab_status[4:1]) == 4'h0)
        else $error("stabilization flags out of order");
    sel_reset_a: assert property (@(posedge aclk) // R18
        $past(!aresetn) |-> stsel_reg == 3'h5 && !sel_reg)
        else $error("select field reset value wrong");
endmodule

/* File: verilog/ccs_cfg.svh */
// register map, field positions, reset values and timing counts of the clock source control
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH
`define CCS_ADDR_MODE       8'h00
`define CCS_ADDR_RING_MODE  8'h04
`define CCS_ADDR_MOSC_STOP  8'h08
`define CCS_ADDR_STAB_STAT  8'h0c
`define CCS_ADDR_STAB_SEL   8'h10
`define CCS_ADDR_PCC        8'h14
`define CCS_MODE_SEL_BIT    0
`define CCS_MODE_STAT_BIT   1
`define CCS_RING_STOP_BIT   0
`define CCS_MOSC_STOP_BIT   7
`define CCS_PCC_MAIN_STOP   7
`define CCS_PCC_FB_OFF      6
`define CCS_PCC_SUB_SEL     4
`define CCS_STAB_SEL_RESET  3'h5
`define CCS_CLK_KHZ         50000
`define CCS_RING_KHZ        240
`define CCS_RING_DIV        (`CCS_CLK_KHZ / `CCS_RING_KHZ)
`define CCS_START_CYCLES    17
`define CCS_STAB_EXP0       11
`define CCS_STAB_EXP1       13
`define CCS_STAB_EXP2       14
`define CCS_STAB_EXP3       15
`define CCS_STAB_EXP4       16
`define CCS_RESP_OKAY       2'h0
`define CCS_RESP_SLVERR     2'h2
`endif

/* File: verilog/ccs_pkg.sv */
// types shared by the clock source control modules
package ccs_pkg;
    typedef enum logic [2:0] {
        CCS_ST_START,
        CCS_ST_RUN,
        CCS_ST_HALT,
        CCS_ST_STOP,
        CCS_ST_STABWAIT
    } ccs_state_e;
    typedef logic [7:0] ccs_byte_t;
endpackage

/* File: verilog/ccs_stab_counter.sv */
// main oscillator stabilization time counter with sticky threshold flags
`timescale 1ns/1ps
`include "ccs_cfg.svh"
module ccs_stab_counter
    import ccs_pkg::*;
#(
    parameter int CNT_W = 17
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             clear,
    input  wire logic             tick,
    input  wire logic [2:0]       limit_sel,
    input  wire logic             limit_on,
    output logic      [4:0]       status,
    output logic                  reached
);
    if (CNT_W < `CCS_STAB_EXP4 + 1) begin : g_bad_width
        $error("ccs_stab_counter: CNT_W too small for the longest wait");
    end

    localparam int EXPS [5] = '{`CCS_STAB_EXP0, `CCS_STAB_EXP1, `CCS_STAB_EXP2,
                                `CCS_STAB_EXP3, `CCS_STAB_EXP4};
    logic [CNT_W-1:0] cnt_reg;
    logic [4:0]       status_reg;
    logic [4:0]       set_now;
    wire  [2:0]       limit_idx = (limit_sel >= 3'h1 && limit_sel <= 3'h5) ?
                                  3'(limit_sel - 3'h1) : 3'h4;
    wire              cnt_full  = cnt_reg[CNT_W-1];

    // status bit 4 is the shortest threshold, bit 0 the longest
    for (genvar i = 0; i < 5; i++) begin : g_thr
        assign set_now[4-i] = (cnt_reg >= (CNT_W'(1) << EXPS[i]))
                              && (!limit_on || 3'(i) <= limit_idx);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            cnt_reg <= '0;
        end else if (tick && !cnt_full) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    // a threshold met in the clearing cycle still sets its flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= 5'h00;
        end else begin
            status_reg <= (clear ? 5'h00 : status_reg) | set_now;
        end
    end

    assign status  = status_reg;
    assign reached = status_reg[3'(4) - limit_idx];
endmodule

/* File: bench/ccs_osc_model.sv */
// resonator models driving the main and subsystem oscillator pins
`timescale 1ns/1ps
module ccs_osc_model (
    input  wire logic aclk,
    input  wire logic main_osc_en,
    output logic      main_osc_clk,
    output logic      sub_osc_clk
);
    int mc = 0;
    int sc = 0;
    initial main_osc_clk = 1'b0;
    initial sub_osc_clk = 1'b0;
    // main resonator stands still while its enable is low
    always @(posedge aclk) begin
        mc <= main_osc_en ? (mc + 1) % 4 : 0;
        if (!main_osc_en) main_osc_clk <= 1'b0;
        else if (mc == 3) main_osc_clk <= ~main_osc_clk;
    end
    // subsystem crystal runs free
    always @(posedge aclk) begin
        sc <= (sc + 1) % 16;
        if (sc == 15) sub_osc_clk <= ~sub_osc_clk;
    end
endmodule

/* File: bench/cpu_clock_source_control_tb_top.sv */
// self-checking bench of the cpu clock source control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
end
module cpu_clock_source_control_tb_top import ccs_pkg::*; ;
    localparam int DIV = 4;
    localparam int MSK [6] = '{1, 1, 'h80, 0, 7, 'hd0};
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, stop_req = 1'b0, halt_req = 1'b0;
    logic        wake_req = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lfsr = 8'h1c, a;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp, rsp;
    logic        awready, wready, bvalid, arready, rvalid, main_osc_clk, sub_osc_clk;
    logic        main_osc_en, internal_ring_oscillator_en, sub_fb_res_off, cpu_clk_en, periph_clk_en;
    logic        cpu_on_main;
    int          err_total = 0, compares = 0, cyc = 0, t0, c, p;
    int          mdl [6] = '{0, 0, 0, 0, 5, 0};

    always #10 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    ccs_clock_ctrl #(.RING_STOPPABLE(1'b1), .RING_DIV(DIV)) uut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .main_osc_clk, .sub_osc_clk, .stop_req, .halt_req, .wake_req,
        .main_osc_en, .internal_ring_oscillator_en, .sub_fb_res_off, .cpu_clk_en, .periph_clk_en,
        .cpu_on_main);
    ccs_osc_model osc (.aclk, .main_osc_en, .main_osc_clk, .sub_osc_clk);

    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        logic ra, wa, bv;
        lfsr = nxt(lfsr);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= {lfsr, 16'h0000, d};
        wstrb <= 4'h1;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(negedge aclk);
            {ra, wa, bv, rsp} = {awready, wready, bvalid, bresp};
            @(posedge aclk);
            if (ra === 1'b1) awvalid <= 1'b0;
            if (wa === 1'b1) wvalid <= 1'b0;
        end while (bv !== 1'b1);
        bready <= 1'b0;
        if (ad < 8'h18) mdl[ad[4:2]] = d & MSK[ad[4:2]];
    endtask

    task automatic rd_reg(input logic [7:0] ad);
        logic ra, rv;
        @(posedge aclk);
        araddr <= ad;
        {arvalid, rready} <= 2'h3;
        do begin
            @(negedge aclk);
            {ra, rv, rd, rsp} = {arready, rvalid, rdata, rresp};
            @(posedge aclk);
            if (ra === 1'b1) arvalid <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
    endtask

    // counts cpu and peripheral clock pulses over a span
    task automatic cnt(input int span);
        c = 0;
        p = 0;
        repeat (span) begin
            @(negedge aclk);
            c += int'(cpu_clk_en !== 1'b0);
            p += int'(periph_clk_en !== 1'b0);
        end
    endtask

    task automatic poll_mode(input logic st);
        int k;
        k = 0;
        do begin
            rd_reg(8'h00);
            k++;
        end while (rd[1] !== st && k < 20);
    endtask

    task test_done;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(60000 * 20);
        err_total++;
        test_done;
    end

    initial begin
        repeat (5) @(posedge aclk);
        @(negedge aclk);
        `CHK("main en", 1'b0, main_osc_en)
        `CHK("ring en", 1'b0, internal_ring_oscillator_en)
        @(posedge aclk) aresetn <= 1'b1;
        t0 = cyc;
        cnt(17 * DIV - 4);
        `CHK("cpu hold", 0, c)
        cnt(30);
        `CHK("cpu start", 1'b1, c > 0)
        `CHK("ring en", 1'b1, internal_ring_oscillator_en)
        rd_reg(8'h00);
        `CHK("mode", 32'h0, rd)
        rd_reg(8'h10);
        `CHK("stab sel", 32'h5, rd)
        for (int k = 1; k <= 5; k++) begin
            wr(8'h10, 8'(k));
            `CHK("wr resp", 2'h0, rsp)
            rd_reg(8'h10);
            `CHK("stab sel", 32'(mdl[4]), rd)
            `CHK("rd resp", 2'h0, rsp)
        end
        wr(8'h10, 8'h01);
        repeat (4) begin
            lfsr = nxt(lfsr);
            a = {lfsr[5:0] | 6'h08, 2'b00};
            wr(a, lfsr);
            `CHK("wr resp", 2'h2, rsp)
            rd_reg(a);
            `CHK("rd resp", 2'h2, rsp)
            `CHK("rd data", 32'h0, rd)
        end
        $display("test registers done");
        do rd_reg(8'h0c); while (rd[4] !== 1'b1 && cyc - t0 < 30000);
        `CHK("stab time", 1'b1, cyc - t0 >= 2047 * 8)
        `CHK("stab flags", 32'h10, rd)
        wr(8'h00, 8'h01);
        poll_mode(1'b1);
        `CHK("mode", 32'h3, rd)
        `CHK("on main", 1'b1, cpu_on_main)
        cnt(64);
        `CHK("periph main", 1'b1, p >= 7 && p <= 9)
        @(posedge aclk) stop_req <= 1'b1;
        @(posedge aclk) stop_req <= 1'b0;
        @(posedge aclk) wake_req <= 1'b1;
        @(posedge aclk) wake_req <= 1'b0;
        cnt(2047 * 8 - 200);
        `CHK("stab wait", 0, c)
        cnt(1200);
        `CHK("stab resume", 1'b1, c > 0)
        wr(8'h04, 8'h01);
        cnt(8);
        `CHK("main en", 1'b1, main_osc_en)
        `CHK("ring en", 1'b0, internal_ring_oscillator_en)
        $display("test main done");
        wr(8'h14, 8'hd0);
        cnt(8);
        `CHK("fb off", 1'b1, sub_fb_res_off)
        `CHK("main en", 1'b0, main_osc_en)
        @(posedge aclk) stop_req <= 1'b1;
        @(posedge aclk) stop_req <= 1'b0;
        cnt(200);
        `CHK("sub stop", 1'b1, c > 0)
        @(posedge aclk) halt_req <= 1'b1;
        @(posedge aclk) halt_req <= 1'b0;
        cnt(4);
        cnt(200);
        `CHK("sub halt", 0, c)
        @(posedge aclk) wake_req <= 1'b1;
        @(posedge aclk) wake_req <= 1'b0;
        cnt(200);
        `CHK("sub wake", 1'b1, c > 0)
        wr(8'h14, 8'h00);
        `CHK("fb on", 1'b0, sub_fb_res_off)
        wr(8'h04, 8'h00);
        cnt(8);
        `CHK("main en", 1'b1, main_osc_en)
        `CHK("ring en", 1'b1, internal_ring_oscillator_en)
        wr(8'h00, 8'h00);
        poll_mode(1'b0);
        `CHK("mode", 32'h0, rd)
        wr(8'h08, 8'h80);
        cnt(8);
        `CHK("main en", 1'b0, main_osc_en)
        rd_reg(8'h0c);
        `CHK("stab clr", 32'h0, rd)
        rd_reg(8'h08);
        `CHK("main stop", 32'(mdl[2]), rd)
        $display("test sub done");
        @(posedge aclk) stop_req <= 1'b1;
        @(posedge aclk) stop_req <= 1'b0;
        cnt(4);
        cnt(40);
        `CHK("stop cpu", 0, c + p)
        @(posedge aclk) wake_req <= 1'b1;
        @(posedge aclk) wake_req <= 1'b0;
        cnt(40);
        `CHK("ring wake", 1'b1, c > 0)
        rd_reg(8'h0c);
        `CHK("stab ring", 32'h0, rd)
        $display("test stop done");
        test_done;
    end
endmodule
